// File: verilog/cam_crt_dram_address_mux.sv
// Function
// - Symmetric DRAM gets refresh bits on column and row lines in the graphics modes.
// - Asymmetric column line 8 is zero; row line 9 is bit 16 in graphics.
// - Window bits come from the bank bits, or system bits 16-20 if linear.
// - Page bit picks system bit 0, 14, 16 or inverted odd page; chained 0.
// - Even/odd interleave is graphics control index 06 bit 1.
// - Chaining is sequencer index 04 bit 3; byte chain bit is bit 1 or 0.
// - The 128K flag is set when graphics index 06 bits 2, 3 are both 0.
// - Odd-page select is misc output bit 5, applied inverted to page.
// - The 64-bit size bit is window bit 2 or 3, routed per layout mode.
//
// Our own choices: the AXI4-Lite register port and the register addresses.
`timescale 1ns/10ps
`default_nettype none
module cam_crt_dram_address_mux (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [cam_pkg::ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [cam_pkg::ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [17:0] crtc_refresh_addr,
    input wire logic [4:0] row_scan_count,
    input wire logic [7:0] char_code,
    input wire logic [1:0] dram_qword_sel,
    input wire logic [20:0] sys_addr_bit,
    input wire logic row_phase,
    output var cam_pkg::cam_addr_t mux_out
);
    cam_pkg::cam_mode_t cfg;
    cam_pkg::cam_compat_t compat;
    logic [4:0] bank;
    logic aw_got;
    logic w_got;
    logic [cam_pkg::ADDR_W-1:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;

    function automatic logic [31:0] merge(input logic [31:0] old,
                                          input logic [31:0] nw,
                                          input logic [3:0] strb);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                r[8*i +: 8] = nw[8*i +: 8];
            end
        end
        return r;
    endfunction

    // Write channel: address and data are taken in either order
    wire aw_hs = s_axi_awvalid && s_axi_awready;
    wire w_hs = s_axi_wvalid && s_axi_wready;
    wire have_aw = aw_got || aw_hs;
    wire have_w = w_got || w_hs;
    wire do_write = have_aw && have_w && !s_axi_bvalid;
    wire [cam_pkg::ADDR_W-1:0] wr_addr = aw_got ? aw_addr : s_axi_awaddr;
    wire [31:0] wr_data = w_got ? w_data : s_axi_wdata;
    wire [3:0] wr_strb = w_got ? w_strb : s_axi_wstrb;
    wire wr_mode = wr_addr == cam_pkg::OFS_MODE;
    wire wr_compat = wr_addr == cam_pkg::OFS_COMPAT;
    wire wr_bank = wr_addr == cam_pkg::OFS_BANK;
    wire wr_ok = wr_mode || wr_compat || wr_bank;
    wire next_aw_got = have_aw && !do_write;
    wire next_w_got = have_w && !do_write;
    wire next_bvalid = do_write || (s_axi_bvalid && !s_axi_bready);
    wire [31:0] mode_word = merge({24'h00_0000, cfg}, wr_data, wr_strb);
    wire [31:0] compat_word = merge(compat, wr_data, wr_strb);
    wire [31:0] bank_word = merge({27'h000_0000, bank}, wr_data, wr_strb);

    // Read channel
    wire ar_hs = s_axi_arvalid && s_axi_arready;
    wire next_rvalid = ar_hs || (s_axi_rvalid && !s_axi_rready);
    wire rd_mode = s_axi_araddr == cam_pkg::OFS_MODE;
    wire rd_compat = s_axi_araddr == cam_pkg::OFS_COMPAT;
    wire rd_bank = s_axi_araddr == cam_pkg::OFS_BANK;
    wire rd_status = s_axi_araddr == cam_pkg::OFS_STATUS;
    wire rd_ok = rd_mode || rd_compat || rd_bank || rd_status;
    wire [31:0] rd_word = rd_mode ? {24'h00_0000, cfg} :
                          rd_compat ? {5'h00, compat[26:0]} :
                          rd_bank ? {27'h000_0000, bank} :
                          rd_status ? {14'h0000, mux_out} : 32'h0000_0000;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_got <= 1'b0;
            w_got <= 1'b0;
            aw_addr <= '0;
            w_data <= cam_pkg::RESET_VALUE;
            w_strb <= 4'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= cam_pkg::RESP_OKAY;
        end else begin
            aw_got <= next_aw_got;
            w_got <= next_w_got;
            if (aw_hs) begin
                aw_addr <= s_axi_awaddr;
            end
            if (w_hs) begin
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
            end
            s_axi_awready <= !next_aw_got && !next_bvalid;
            s_axi_wready <= !next_w_got && !next_bvalid;
            s_axi_bvalid <= next_bvalid;
            if (do_write) begin
                s_axi_bresp <= wr_ok ? cam_pkg::RESP_OKAY
                                     : cam_pkg::RESP_SLVERR;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cfg <= cam_pkg::cam_mode_t'(cam_pkg::RESET_VALUE[7:0]);
            compat <= cam_pkg::RESET_VALUE;
            bank <= cam_pkg::RESET_VALUE[4:0];
        end else if (do_write) begin
            if (wr_mode) begin
                cfg <= mode_word[7:0];
            end
            if (wr_compat) begin
                compat <= {5'h00, compat_word[26:0]};
            end
            if (wr_bank) begin
                bank <= bank_word[4:0];
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= cam_pkg::RESET_VALUE;
            s_axi_rresp <= cam_pkg::RESP_OKAY;
        end else begin
            s_axi_arready <= !next_rvalid;
            s_axi_rvalid <= next_rvalid;
            if (ar_hs) begin
                s_axi_rdata <= rd_word;
                s_axi_rresp <= rd_ok ? cam_pkg::RESP_OKAY
                                     : cam_pkg::RESP_SLVERR;
            end
        end
    end

    // Address datapath, combinational from the registered controls
    wire [17:0] rf = crtc_refresh_addr;
    wire [4:0] rs = row_scan_count;
    wire [7:0] cc = char_code;
    wire [1:0] qs = dram_qword_sel;
    wire [2:0] cm = compat.char_map;
    wire b32 = cfg.bus32;
    wire m_word = cfg.mode == cam_pkg::MODE_WORD;
    wire m_dword = cfg.mode == cam_pkg::MODE_DWORD;
    wire m_std = cfg.mode == cam_pkg::MODE_STD_TEXT;
    wire m_enh = cfg.mode == cam_pkg::MODE_ENH_TEXT;
    // Undefined mode codes fall back to the byte layout and byte routing
    wire m_byte = !(m_word || m_dword || m_std || m_enh);
    wire graphics = !(m_std || m_enh);
    wire [8:0] col_byte = {rf[16], rf[6:0], b32 ? rf[17] : qs[0]};
    wire [8:0] row_byte = {rf[15], b32 ? rs[1] : rf[14],
                           b32 ? rs[0] : rf[13], rf[12:7]};
    wire [8:0] col_word = {rf[16], rf[5:0], b32 ? rf[13] : rf[15],
                           b32 ? rf[17] : qs[1]};
    wire [8:0] row_word = {rf[14], b32 ? rs[1] : rf[13],
                           b32 ? rs[0] : rf[12], rf[11:6]};
    wire [8:0] col_dword = {rf[16], rf[4:0], rf[15], rf[14],
                            b32 ? rf[17] : qs[0]};
    wire [8:0] row_dword = {rf[13], b32 ? rs[1] : rf[12],
                            b32 ? rs[0] : rf[11], rf[10:5]};
    wire [8:0] col_std = {1'b0, cc[1:0], rs, b32 ? rf[17] : qs[1]};
    wire [8:0] row_std = {cm[1], cm[0], cm[2], cc[7:2]};
    wire [8:0] col_enh = {1'b0, cc[6:0], b32 ? cc[7] : qs[1]};
    wire [8:0] row_enh = {cm[1], cm[0], cm[2], 1'b0, rs};
    wire [8:0] col_sel = m_word ? col_word : m_dword ? col_dword :
                         m_std ? col_std : m_enh ? col_enh : col_byte;
    wire [8:0] row_sel = m_word ? row_word : m_dword ? row_dword :
                         m_std ? row_std : m_enh ? row_enh : row_byte;
    wire col8 = cfg.asym ? 1'b0 : col_sel[8];
    wire row9 = cfg.asym && graphics && rf[16];
    wire [9:0] next_dram = row_phase ? {row9, row_sel}
                                     : {1'b0, col8, col_sel[7:0]};

    wire [4:0] next_win = cfg.linear ? sys_addr_bit[20:16] : bank;
    wire oddeven = compat.gfx06[cam_pkg::GFX_ODDEVEN_BIT];
    wire chain_on = compat.seq04[cam_pkg::SEQ_CHAIN_BIT];
    wire ext_mem = compat.seq04[cam_pkg::SEQ_EXT_MEM_BIT];
    wire map_lo = compat.gfx06[cam_pkg::GFX_MAP_LO_BIT];
    wire map_hi = compat.gfx06[cam_pkg::GFX_MAP_HI_BIT];
    // Mixed map bits leave the flag clear, the safe 64K view
    wire window_128k_flag = !map_lo && !map_hi;
    wire odd_page_select = compat.misc_out[cam_pkg::MISC_PAGE_BIT];
    wire size_bit = cfg.mem512 ? next_win[3] : next_win[2];
    wire page_base = chain_on ? 1'b0 : !oddeven ? sys_addr_bit[0] :
                     !ext_mem ? sys_addr_bit[14] :
                     window_128k_flag ? sys_addr_bit[16] :
                     !odd_page_select;
    // Chaining keeps the page bit low even with a 64-bit size bit routed
    wire next_page = (cfg.wide64 && m_byte && !chain_on) ? size_bit
                                                       : page_base;
    wire next_link = (cfg.wide64 && m_word) ? size_bit :
                     (m_byte && !chain_on) ? sys_addr_bit[1] : 1'b0;
    wire next_alt = (cfg.wide64 && m_dword) ? size_bit :
                    m_word ? sys_addr_bit[2] : 1'b0;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            mux_out <= '0;
        end else begin
            mux_out <= {next_alt, next_link, next_page, next_win, next_dram};
        end
    end

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    byte_col_map_a: assert property (
        m_byte && !cfg.asym && !row_phase |=> mux_out.dram_addr[8:1] ==
            {$past(rf[16]), $past(rf[6:0])})
        else $error("byte mode column lines wrong");
    asym_col8_a: assert property (
        cfg.asym && !row_phase |=> mux_out.dram_addr[8] == 1'b0)
        else $error("asymmetric column line 8 not zero");
    asym_row9_a: assert property (
        cfg.asym && row_phase |=> mux_out.dram_addr[9] ==
            ($past(graphics) && $past(rf[16])))
        else $error("asymmetric row line 9 wrong");
    window_src_a: assert property (
        ##1 mux_out.window_addr == ($past(cfg.linear) ?
            $past(sys_addr_bit[20:16]) : $past(bank)))
        else $error("window bits from wrong source");
    chain_page_a: assert property (
        chain_on |=> !mux_out.page_select_addr)
        else $error("page bit not zero while chained");
    nointl_page_a: assert property (
        !chain_on && !oddeven && !(cfg.wide64 && m_byte)
            |=> mux_out.page_select_addr == $past(sys_addr_bit[0]))
        else $error("page bit not system bit 0");
    byte_link_a: assert property (
        m_byte && !cfg.wide64 |=> mux_out.link_select_addr ==
            (!$past(chain_on) && $past(sys_addr_bit[1])))
        else $error("byte mode chain bit wrong");
    win128_page_a: assert property (
        !chain_on && oddeven && ext_mem && !map_lo && !map_hi && !cfg.wide64
            |=> mux_out.page_select_addr == $past(sys_addr_bit[16]))
        else $error("128K page bit not system bit 16");
    odd_page_a: assert property (
        !chain_on && oddeven && ext_mem && map_lo && map_hi && !cfg.wide64
            |=> mux_out.page_select_addr == !$past(odd_page_select))
        else $error("page bit not inverted odd-page select");
    size_alt_a: assert property (
        cfg.wide64 && m_dword |=> mux_out.alt_addr_bit ==
            ($past(cfg.mem512) ? mux_out.window_addr[3]
                               : mux_out.window_addr[2]))
        else $error("size bit not on alternate bit");
    row_phase_a: assert property (
        m_byte && !b32 && row_phase |=> mux_out.dram_addr[8:0] ==
            {$past(rf[15:7])})
        else $error("row set not presented in row phase");
endmodule
`default_nettype wire

// File: verilog/cam_pkg.sv
`default_nettype none
package cam_pkg;
    // Register byte offsets
    localparam logic [4:0] OFS_MODE = 5'h00;
    localparam logic [4:0] OFS_COMPAT = 5'h04;
    localparam logic [4:0] OFS_BANK = 5'h08;
    localparam logic [4:0] OFS_STATUS = 5'h0C;
    localparam int ADDR_W = 5;

    // Layout mode codes in the mode field
    localparam logic [2:0] MODE_BYTE = 3'h0;
    localparam logic [2:0] MODE_WORD = 3'h1;
    localparam logic [2:0] MODE_DWORD = 3'h2;
    localparam logic [2:0] MODE_STD_TEXT = 3'h3;
    localparam logic [2:0] MODE_ENH_TEXT = 3'h4;

    // Field positions inside the compat register
    localparam int SEQ04_LSB = 0;
    localparam int GFX06_LSB = 8;
    localparam int MISC_LSB = 16;
    localparam int CMAP_LSB = 24;
    localparam int SEQ_EXT_MEM_BIT = 1;
    localparam int SEQ_CHAIN_BIT = 3;
    localparam int GFX_ODDEVEN_BIT = 1;
    localparam int GFX_MAP_LO_BIT = 2;
    localparam int GFX_MAP_HI_BIT = 3;
    localparam int MISC_PAGE_BIT = 5;

    localparam logic [31:0] RESET_VALUE = 32'h0000_0000;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef struct packed {
        logic mem512;
        logic wide64;
        logic linear;
        logic asym;
        logic bus32;
        logic [2:0] mode;
    } cam_mode_t;

    typedef struct packed {
        logic [4:0] pad;
        logic [2:0] char_map;
        logic [7:0] misc_out;
        logic [7:0] gfx06;
        logic [7:0] seq04;
    } cam_compat_t;

    typedef struct packed {
        logic alt_addr_bit;
        logic link_select_addr;
        logic page_select_addr;
        logic [4:0] window_addr;
        logic [9:0] dram_addr;
    } cam_addr_t;
endpackage
`default_nettype wire

// File: tb/cam_dram_model.sv
`timescale 1ns/10ps
`default_nettype none
module cam_dram_model (
    input wire logic aclk,
    input wire logic row_phase,
    input wire cam_pkg::cam_addr_t addr,
    output logic [9:0] row_latched,
    output logic [9:0] col_latched
);
    logic phase_q = 1'h0;
    // The address lines trail the phase input by one register stage
    always_ff @(posedge aclk) begin
        phase_q <= row_phase;
        if (phase_q) begin
            row_latched <= addr.dram_addr;
        end else begin
            col_latched <= addr.dram_addr;
        end
    end
endmodule
`default_nettype wire

// File: tb/crt_dram_address_mux_bench.sv
`timescale 1ns/10ps
`default_nettype none
module crt_dram_address_mux_bench;
    logic aclk = 1'h0;
    logic aresetn = 1'h0;
    logic [4:0] awaddr = '0, araddr = '0;
    logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0;
    logic arvalid = 1'h0, rready = 1'h0;
    logic [31:0] wdata = '0;
    logic [3:0] wstrb = '0;
    logic awready, wready, bvalid, arready, rvalid;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata;
    logic [17:0] rf = '0;
    logic [4:0] rs = '0;
    logic [7:0] cc = '0;
    logic [1:0] qs = '0;
    logic [20:0] sy = '0;
    logic [9:0] row_lat, col_lat;
    logic rp = 1'h0;
    cam_pkg::cam_addr_t mux_out;
    int err_count = 0, cmp_count = 0;
    logic [15:0] corner [4] = '{16'h0000, 16'h0202, 16'h0E02, 16'h0008};

    always #50 aclk = ~aclk;

    cam_crt_dram_address_mux uut (.aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .crtc_refresh_addr(rf), .row_scan_count(rs), .char_code(cc),
        .dram_qword_sel(qs), .sys_addr_bit(sy), .row_phase(rp),
        .mux_out(mux_out));

    cam_dram_model dram (.aclk(aclk), .row_phase(rp), .addr(mux_out),
        .row_latched(row_lat), .col_latched(col_lat));

    task automatic results();
        if (err_count == 0 && cmp_count > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    task automatic chk_word(string what, logic [31:0] exp, logic [31:0] got);
        cmp_count++;
        if (got !== exp) begin
            err_count++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic chk_mux(cam_pkg::cam_addr_t exp, cam_pkg::cam_addr_t got);
        cmp_count++;
        if (got !== exp) begin
            err_count++;
            $display("ERROR mux_out expected %h seen %h", exp, got);
        end
    endtask

    // Each bus task starts one edge late so a release never meets a new
    // request in the same time step
    task automatic axi_wr(logic [4:0] a, logic [31:0] d, logic [3:0] s,
            output logic [1:0] resp);
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        wstrb <= s;
        awvalid <= 1'h1;
        wvalid <= 1'h1;
        bready <= 1'h1;
        // Only the watchdog ends a wait for the answer
        do begin
            @(posedge aclk);
            if (awvalid && awready) awvalid <= 1'h0;
            if (wvalid && wready) wvalid <= 1'h0;
        end while (!bvalid);
        resp = bresp;
        bready <= 1'h0;
    endtask

    task automatic axi_rd(logic [4:0] a, output logic [31:0] d,
            output logic [1:0] resp);
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'h1;
        rready <= 1'h1;
        do begin
            @(posedge aclk);
            if (arvalid && arready) arvalid <= 1'h0;
        end while (!rvalid);
        d = rdata;
        resp = rresp;
        rready <= 1'h0;
    endtask

    function automatic cam_pkg::cam_addr_t exp_mux(logic [7:0] m,
            logic [31:0] c, logic [4:0] bk);
        cam_pkg::cam_addr_t e;
        logic [2:0] md, cm;
        logic [7:0] col;
        logic [8:0] row;
        logic b, txt, byt, wb;
        e = '0;
        md = (m[2:0] > cam_pkg::MODE_ENH_TEXT) ? cam_pkg::MODE_BYTE : m[2:0];
        b = m[3];
        cm = c[26:24];
        txt = md >= cam_pkg::MODE_STD_TEXT;
        byt = md == cam_pkg::MODE_BYTE;
        case (md)
            cam_pkg::MODE_WORD: begin
                col = {rf[5:0], b ? rf[13] : rf[15], b ? rf[17] : qs[1]};
                row = {rf[14], b ? rs[1] : rf[13], b ? rs[0] : rf[12],
                       rf[11:6]};
            end
            cam_pkg::MODE_DWORD: begin
                col = {rf[4:0], rf[15], rf[14], b ? rf[17] : qs[0]};
                row = {rf[13], b ? rs[1] : rf[12], b ? rs[0] : rf[11],
                       rf[10:5]};
            end
            cam_pkg::MODE_STD_TEXT: begin
                col = {cc[1:0], rs, b ? rf[17] : qs[1]};
                row = {cm[1], cm[0], cm[2], cc[7:2]};
            end
            cam_pkg::MODE_ENH_TEXT: begin
                col = {cc[6:0], b ? cc[7] : qs[1]};
                row = {cm[1], cm[0], cm[2], 1'h0, rs};
            end
            default: begin
                col = {rf[6:0], b ? rf[17] : qs[0]};
                row = {rf[15], b ? rs[1] : rf[14], b ? rs[0] : rf[13],
                       rf[12:7]};
            end
        endcase
        e.dram_addr = rp ? {~txt & m[4] & rf[16], row}
                         : {1'h0, ~txt & ~m[4] & rf[16], col};
        e.window_addr = m[5] ? sy[20:16] : bk;
        wb = m[7] ? e.window_addr[3] : e.window_addr[2];
        e.page_select_addr = c[3] ? 1'h0 : ~c[9] ? sy[0] : ~c[1] ? sy[14]
            : (c[11:10] == 2'h0) ? sy[16] : ~c[21];
        if (m[6] && byt && !c[3]) e.page_select_addr = wb;
        e.link_select_addr = (m[6] && md == cam_pkg::MODE_WORD) ? wb
            : (byt && !c[3]) ? sy[1] : 1'h0;
        e.alt_addr_bit = (m[6] && md == cam_pkg::MODE_DWORD) ? wb
            : (md == cam_pkg::MODE_WORD) ? sy[2] : 1'h0;
        return e;
    endfunction

    task automatic configure(logic [7:0] m, logic [31:0] c, logic [4:0] bk);
        logic [31:0] d;
        logic [1:0] r;
        cam_pkg::cam_addr_t e;
        axi_wr(cam_pkg::OFS_MODE, 32'(m), 4'hF, r);
        axi_wr(cam_pkg::OFS_COMPAT, ~c, 4'hF, r);
        axi_wr(cam_pkg::OFS_COMPAT, c, 4'hE, r);
        axi_wr(cam_pkg::OFS_COMPAT, c, 4'h1, r);
        axi_wr(cam_pkg::OFS_BANK, 32'(bk), 4'hF, r);
        chk_word("bresp", 32'(cam_pkg::RESP_OKAY), 32'(r));
        axi_rd(cam_pkg::OFS_COMPAT, d, r);
        chk_word("compat", c & 32'h07FF_FFFF, d);
        repeat (8) begin
            @(posedge aclk);
            rf <= 18'($urandom());
            rs <= 5'($urandom());
            cc <= 8'($urandom());
            qs <= 2'($urandom());
            sy <= 21'($urandom());
            rp <= 1'($urandom());
            @(posedge aclk);
            #1;
            e = exp_mux(m, c, bk);
            chk_mux(e, mux_out);
            axi_rd(cam_pkg::OFS_STATUS, d, r);
            chk_word("status", {14'h0, e}, d);
            // The far side has latched the settled lines by now
            chk_word("dram latch", 32'(e.dram_addr),
                     32'(rp ? row_lat : col_lat));
        end
    endtask

    initial begin
        int i;
        logic [31:0] d, c;
        logic [1:0] r;
        void'($urandom(17625));
        repeat (5) @(posedge aclk);
        aresetn <= 1'h1;
        #1;
        chk_word("reset mux_out", 32'h0, 32'(mux_out));
        for (i = 0; i < 16; i += 4) begin
            axi_rd(5'(i), d, r);
            chk_word("reset reg", 32'h0, d);
        end
        axi_wr(5'h14, 32'hFFFF_FFFF, 4'hF, r);
        chk_word("unmapped bresp", 32'(cam_pkg::RESP_SLVERR), 32'(r));
        axi_wr(cam_pkg::OFS_STATUS, 32'hFFFF_FFFF, 4'hF, r);
        chk_word("status bresp", 32'(cam_pkg::RESP_SLVERR), 32'(r));
        axi_rd(5'h14, d, r);
        chk_word("unmapped rdata", 32'h0, d);
        chk_word("unmapped rresp", 32'(cam_pkg::RESP_SLVERR), 32'(r));
        // First 32 configurations sweep every mode over the page selections except system bit 14
        for (i = 0; i < 150; i++) begin
            if (i < 32) begin
                c = {5'h0, 3'($urandom()), 8'($urandom()), corner[i / 8]};
            end else begin
                c = $urandom();
            end
            configure({5'($urandom()), 3'(i)}, c, 5'($urandom()));
        end
        axi_rd(cam_pkg::OFS_BANK, d, r);
        chk_word("bank rresp", 32'(cam_pkg::RESP_OKAY), 32'(r));
        results();
    end

    initial begin
        repeat (80000) @(posedge aclk);
        err_count++;
        results();
    end
endmodule
`default_nettype wire
